// ### dv/supply_analog_model.sv
// Behavioural supply comparators and slow oscillator facing the monitor control.
`timescale 1ns/100ps
module supply_analog_model #(
  parameter logic [11:0] TH0 = 12'h700,
  parameter logic [11:0] TH1 = 12'hA00,
  parameter logic [11:0] TH2 = 12'hD00,
  parameter int SLOW_HALF = 2
) (
  input wire logic clock,
  input wire logic [11:0] supplyLevel,
  output logic slowOsc,
  output logic cmpAbove0,
  output logic cmpAbove1,
  output logic cmpAbove2
);
  int divCnt = 0;
  initial slowOsc = 1'b0;
  // The oscillator runs free, so release counts keep advancing without any frame.
  always @(posedge clock)
  begin
    divCnt <= (divCnt == SLOW_HALF - 1) ? 0 : divCnt + 1;
    if (divCnt == SLOW_HALF - 1)
      slowOsc <= ~slowOsc;
  end
  assign cmpAbove0 = supplyLevel > TH0;
  assign cmpAbove1 = supplyLevel > TH1;
  assign cmpAbove2 = supplyLevel > TH2;
endmodule : supply_analog_model

// ### dv/supply_monitor_checker_assertions.sv
// Port-level checker for the supply-voltage monitor control.
`timescale 1ns/100ps
module supply_monitor_checker #(
  parameter int RESTART_CYCLES = 250
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic partialResetn,
  input wire logic slowOsc,
  input wire logic cmpAbove0,
  input wire logic cmpAbove1,
  input wire logic cmpAbove2,
  input wire logic comparatorMode,
  input wire logic protectUnlock,
  input wire logic enableWrite,
  input wire logic det0CtrlWrite,
  input wire logic det1CtrlWrite,
  input wire supply_monitor_pkg::reg_byte_t writeData,
  input wire supply_monitor_pkg::reg_byte_t detectEnableReg,
  input wire supply_monitor_pkg::reg_byte_t det0CtrlReg,
  input wire supply_monitor_pkg::reg_byte_t det1CtrlReg,
  input wire supply_monitor_pkg::reg_byte_t detectLevelReg,
  input wire logic det0ResetReq,
  input wire logic det1ResetReq,
  input wire logic det1IrqReq,
  input wire logic comparatorOut1,
  input wire logic comparatorOut2
);
  import supply_monitor_pkg::*;
  int holdCnt;
  int tickCnt;
  logic slowPrev_q;
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  // ------
  // Helper counters
  // ------
  always_ff @(posedge clock)
    if (!resetn)
      holdCnt <= 0;
    else
      holdCnt <= det1ResetReq ? holdCnt + 1 : 0;
  always_ff @(posedge clock)
    slowPrev_q <= slowOsc;
  // Slow ticks are counted only while the supply stays above the lowest threshold.
  always_ff @(posedge clock)
    if (!resetn || !cmpAbove0)
      tickCnt <= 0;
    else if (slowOsc && !slowPrev_q)
      tickCnt <= tickCnt + 1;
  // ------
  // Properties
  // ------
  a_lock_enable: assert property ((enableWrite && !protectUnlock) |=> $stable(detectEnableReg))
    else $error("enable register changed while locked");
  a_take_enable: assert property ((enableWrite && protectUnlock) |=>
    detectEnableReg == ($past(writeData) & 8'hE1)) else $error("enable write not taken");
  a_det2_level_off: assert property ((!detectEnableReg[7] && $past(!detectEnableReg[7])) |->
    detectLevelReg[3]) else $error("detector 2 level low while disabled");
  a_flag_clear_only: assert property (($fell(det1CtrlReg[2]) && $past(resetn)) |->
    $past(det1CtrlWrite && protectUnlock && !writeData[2])) else $error("flag fell unasked");
  a_irq_cause: assert property (det1IrqReq |->
    $past(det1CtrlReg[0] && !det1CtrlReg[6] && detectEnableReg[6])) else $error("stray irq");
  a_restart_len: assert property (($fell(det1ResetReq) && $past(resetn)) |->
    holdCnt == RESTART_CYCLES) else $error("detector 1 reset length wrong");
  a_det0_hold: assert property ((det0ResetReq && !cmpAbove0 && $past(!cmpAbove0)) |=>
    det0ResetReq) else $error("detector 0 reset dropped while supply low");
  a_det0_release: assert property (($fell(det0ResetReq) && $past(resetn)) |->
    tickCnt >= 32) else $error("detector 0 reset released early");
  a_partial_keep: assert property ((!partialResetn && !enableWrite && !det0CtrlWrite) |=>
    $stable(detectEnableReg) && $stable(det0CtrlReg)) else $error("partial reset hit registers");
  a_cmp_follow: assert property ((comparatorMode && $past(comparatorMode) && $past(resetn)) |->
    comparatorOut1 == $past(cmpAbove1) && comparatorOut2 == $past(cmpAbove2))
    else $error("comparator output does not follow");
endmodule : supply_monitor_checker

bind supply_voltage_monitor_control supply_monitor_checker #(.RESTART_CYCLES(RESTART_CYCLES)) i_chk (
  .clock(clock), .resetn(resetn), .partialResetn(partialResetn), .slowOsc(slowOsc),
  .cmpAbove0(cmpAbove0), .cmpAbove1(cmpAbove1), .cmpAbove2(cmpAbove2),
  .comparatorMode(comparatorMode), .protectUnlock(protectUnlock), .enableWrite(enableWrite),
  .det0CtrlWrite(det0CtrlWrite), .det1CtrlWrite(det1CtrlWrite), .writeData(writeData),
  .detectEnableReg(detectEnableReg), .det0CtrlReg(det0CtrlReg), .det1CtrlReg(det1CtrlReg),
  .detectLevelReg(detectLevelReg), .det0ResetReq(det0ResetReq), .det1ResetReq(det1ResetReq),
  .det1IrqReq(det1IrqReq), .comparatorOut1(comparatorOut1), .comparatorOut2(comparatorOut2));

// ### dv/tb_supply_voltage_monitor_control.sv
// Self-checking bench for the supply-voltage monitor control.
`timescale 1ns/100ps
module tb_supply_voltage_monitor_control;
  import supply_monitor_pkg::*;
  localparam int RESTART = 3;
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic partialResetn = 1'b1;
  logic comparatorMode = 1'b0;
  logic protectUnlock = 1'b0;
  logic [4:0] strobe = 5'h00;
  reg_byte_t writeData = 8'h00;
  logic [11:0] supplyLevel = 12'hF00;
  logic slowOsc, cmpAbove0, cmpAbove1, cmpAbove2;
  reg_byte_t detectEnableReg, det0CtrlReg, det1CtrlReg, det2CtrlReg, detectLevelReg, edgeSelReg;
  logic det0ResetReq, det1ResetReq, det2ResetReq, det1IrqReq, det2IrqReq, cmpOut1, cmpOut2;
  int errTotal = 0;
  int checkCount = 0;
  int n;
  reg_byte_t rnd;
  always #2 clock = ~clock;
  supply_voltage_monitor_control #(.SETTLE_CYCLES(4), .RESTART_CYCLES(RESTART)) i_dut (
    .clock(clock), .resetn(resetn), .partialResetn(partialResetn), .slowOsc(slowOsc),
    .cmpAbove0(cmpAbove0), .cmpAbove1(cmpAbove1), .cmpAbove2(cmpAbove2),
    .comparatorMode(comparatorMode), .protectUnlock(protectUnlock),
    .enableWrite(strobe[0]), .det0CtrlWrite(strobe[1]), .det1CtrlWrite(strobe[2]),
    .det2CtrlWrite(strobe[3]), .edgeSelWrite(strobe[4]), .writeData(writeData),
    .detectEnableReg(detectEnableReg), .det0CtrlReg(det0CtrlReg), .det1CtrlReg(det1CtrlReg),
    .det2CtrlReg(det2CtrlReg), .detectLevelReg(detectLevelReg), .edgeSelReg(edgeSelReg),
    .det0ResetReq(det0ResetReq), .det1ResetReq(det1ResetReq), .det2ResetReq(det2ResetReq),
    .det1IrqReq(det1IrqReq), .det2IrqReq(det2IrqReq), .comparatorOut1(cmpOut1),
    .comparatorOut2(cmpOut2));
  supply_analog_model i_model (.clock(clock), .supplyLevel(supplyLevel), .slowOsc(slowOsc),
    .cmpAbove0(cmpAbove0), .cmpAbove1(cmpAbove1), .cmpAbove2(cmpAbove2));
  // ------
  // Helpers
  // ------
  task automatic wrapUp();
    $display("Checks %0d mismatches %0d", checkCount, errTotal);
    if (errTotal == 0 && checkCount > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : wrapUp
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checkCount++;
    if (seen !== exp)
    begin
      errTotal++;
      $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check
  function automatic logic above(input logic [11:0] lvl, input logic [11:0] th);
    return lvl > th;
  endfunction : above
  function automatic logic probe(input int sel);
    case (sel)
      0: return det1IrqReq;
      1: return det1ResetReq;
      default: return det0ResetReq;
    endcase
  endfunction : probe
  task automatic wr(input int sel, input reg_byte_t d);
    @(negedge clock);
    writeData = d;
    strobe[sel] = 1'b1;
    @(negedge clock);
    strobe = 5'h00;
  endtask : wr
  task automatic setSupply(input logic [11:0] v);
    @(negedge clock);
    supplyLevel = v;
  endtask : setSupply
  task automatic await(input int sel, input logic v, input int lim, output int cnt);
    cnt = 0;
    while (probe(sel) !== v)
    begin
      @(negedge clock);
      cnt++;
      if (cnt > lim)
      begin
        errTotal++;
        $display("[FAIL] probe %0d expected %0b seen timeout", sel, v);
        wrapUp();
      end
    end
  endtask : await
  task automatic countIrq(output int c);
    c = 0;
    repeat (20)
    begin
      @(negedge clock);
      if (det1IrqReq !== 1'b0 || det2IrqReq !== 1'b0)
        c++;
    end
  endtask : countIrq
  // ------
  // Scenarios
  // ------
  initial
  begin
    rnd = reg_byte_t'($urandom(15));
    repeat (5) @(negedge clock);
    resetn = 1'b1;
    check("level reg reset", detectLevelReg, 8'h08);
    check("det1 ctrl reset", det1CtrlReg, 8'h08);
    wr(0, rnd);
    check("enable locked", detectEnableReg, 8'h00);
    protectUnlock = 1'b1;
    wr(0, rnd);
    check("enable open", detectEnableReg, rnd & 8'hE1);
    rnd = reg_byte_t'($urandom);
    wr(4, rnd);
    check("edge select", edgeSelReg, rnd & 8'h06);
    wr(4, 8'h00);
    wr(0, 8'h00);
    $display("Test registers done");
    wr(2, 8'h02);
    wr(3, 8'h02);
    check("det2 ctrl", det2CtrlReg, 8'h02);
    setSupply(12'hC00);
    wr(0, 8'hC0);
    check("level before settle", detectLevelReg[3], 1'b1);
    repeat (12) @(negedge clock);
    check("det2 level below", detectLevelReg[3], 1'b0);
    check("det1 level above", det1CtrlReg[3], 1'b1);
    wr(0, 8'h40);
    @(negedge clock);
    check("det2 level off", detectLevelReg[3], 1'b1);
    wr(0, 8'hC0);
    $display("Test levels done");
    wr(2, 8'h83);
    setSupply(12'h900);
    await(0, 1'b1, 20, n);
    check("flag on fall", det1CtrlReg[2], 1'b1);
    check("det1 level below", det1CtrlReg[3], 1'b0);
    setSupply(12'hC00);
    countIrq(n);
    check("no irq on rise", n, 0);
    wr(2, 8'h87);
    check("flag kept by one", det1CtrlReg[2], 1'b1);
    wr(2, 8'h83);
    check("flag cleared by zero", det1CtrlReg[2], 1'b0);
    wr(4, 8'h02);
    setSupply(12'h900);
    await(0, 1'b1, 20, n);
    setSupply(12'hC00);
    await(0, 1'b1, 20, n);
    @(negedge clock);
    partialResetn = 1'b0;
    @(negedge clock);
    partialResetn = 1'b1;
    check("enable kept", detectEnableReg, 8'hC0);
    check("flag kept", det1CtrlReg[2], 1'b1);
    check("edge cleared", edgeSelReg, 8'h00);
    wr(2, 8'h03);
    setSupply(12'h900);
    countIrq(n);
    check("no irq on fall", n, 0);
    setSupply(12'hC00);
    await(0, 1'b1, 20, n);
    $display("Test interrupt edges done");
    wr(2, 8'hC3);
    setSupply(12'h900);
    await(1, 1'b1, 20, n);
    await(1, 1'b0, 20, n);
    check("restart length", n, RESTART);
    setSupply(12'hC00);
    wr(2, 8'h02);
    $display("Test detector 1 reset done");
    rnd = reg_byte_t'($urandom % 4);
    wr(1, {2'b00, rnd[1:0], 4'h0});
    wr(0, 8'hE0);
    repeat (16 * (1 << rnd[1:0]) + 8) @(negedge clock);
    wr(1, {2'b00, rnd[1:0], 4'h1});
    check("det0 ctrl", det0CtrlReg, {2'b00, rnd[1:0], 4'h1});
    setSupply(12'h600);
    await(2, 1'b1, 300, n);
    repeat (40) @(negedge clock);
    check("det0 held low", det0ResetReq, 1'b1);
    setSupply(12'hF00);
    await(2, 1'b0, 2000, n);
    check("det0 release wait", n >= 128, 1'b1);
    $display("Test detector 0 done");
    comparatorMode = 1'b1;
    repeat (8)
    begin
      setSupply(12'($urandom));
      repeat (2) @(negedge clock);
      check("comparator 1", cmpOut1, above(supplyLevel, 12'hA00));
      check("comparator 2", cmpOut2, above(supplyLevel, 12'hD00));
    end
    $display("Test comparator mode done");
    wrapUp();
  end
endmodule : tb_supply_voltage_monitor_control

// ### src/det_channel_if.sv
// Configuration and result signals between the control block and one detector channel.
`timescale 1ns/100ps
interface det_channel_if;
  logic enable;
  logic filterDisable;
  supply_monitor_pkg::div_sel_t divSel;
  logic level;
  logic settled;
  modport ctrl (output enable, output filterDisable, output divSel, input level, input settled);
  modport chan (input enable, input filterDisable, input divSel, output level, output settled);
endinterface : det_channel_if

// ### src/detector_channel.sv
// One detector channel: settle wait after enable and the sampling digital filter.
`timescale 1ns/100ps
`include "supply_monitor_consts.svh"
module detector_channel #(
  parameter int SAMPLES = 2,
  parameter int SETTLE_CYCLES = 25000
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic slowTick,
  input wire logic rawAbove,
  det_channel_if.chan ch
);
  import supply_monitor_pkg::*;

  localparam int CW = $clog2(SETTLE_CYCLES + 1);
  localparam logic [CW-1:0] SETTLE_LAST = CW'(SETTLE_CYCLES);

  if (SAMPLES < 2 || SAMPLES > 8 || SETTLE_CYCLES < 1)
  begin : bad_param
    $error("detector_channel parameters out of range");
  end

  logic [CW-1:0] settle_q;
  logic [2:0] div_q;
  logic [SAMPLES-1:0] shift_q;
  logic filt_q;
  logic level_q;
  logic [2:0] divMask;
  logic sampleTick;

  // ----------------------------------------------------------------
  // Settle wait
  // ----------------------------------------------------------------
  // Dropping the enable restarts the wait, so every 0 to 1 change waits in full.
  always_ff @(posedge clock)
  begin
    if (!resetn || !ch.enable)
      settle_q <= '0;
    else if (settle_q != SETTLE_LAST)
      settle_q <= settle_q + CW'(1);
  end
  assign ch.settled = (settle_q == SETTLE_LAST);

  // ----------------------------------------------------------------
  // Sampling clock divider
  // ----------------------------------------------------------------
  always_comb
  begin
    case (ch.divSel)
      2'h0: divMask = 3'h0;
      2'h1: divMask = 3'h1;
      2'h2: divMask = 3'h3;
      default: divMask = 3'h7;
    endcase
  end
  assign sampleTick = slowTick && ((div_q & divMask) == 3'h0);

  always_ff @(posedge clock)
  begin
    if (!resetn)
      div_q <= 3'h0;
    else if (slowTick)
      div_q <= div_q + 3'h1;
  end

  // ----------------------------------------------------------------
  // Filter
  // ----------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      shift_q <= '1;
      filt_q <= 1'b1;
    end
    else if (sampleTick)
    begin
      shift_q <= {shift_q[SAMPLES-2:0], rawAbove};
      if (&shift_q)
        filt_q <= 1'b1;
      else if (~|shift_q)
        filt_q <= 1'b0;
    end
  end

  // A disabled channel, or one still settling, reports the supply as above threshold.
  always_ff @(posedge clock)
  begin
    if (!resetn || !ch.enable || !ch.settled)
      level_q <= 1'b1;
    else if (ch.filterDisable)
      level_q <= rawAbove;
    else
      level_q <= filt_q;
  end
  assign ch.level = level_q;
endmodule : detector_channel

// ### src/supply_monitor_consts.svh
// Bit positions, reset values and timing figures of the supply-voltage monitor control.
// Functional notes
// - Detector 0 reacts only to falling supply; gives reset only, no level, no interrupt.
// - Detectors 1 and 2 detect rising or falling crossings of their own thresholds.
// - Detector 0 reset is held while supply is below threshold zero.
// - Detector 1/2 reset asserts on drop below threshold, releases after fixed delay; code asserts it on the crossing picked by the direction and both-edge bits.
// - Detector 1/2 interrupt raised on falling, rising or both edges as selected.
// - Each detector has switchable filter; slow oscillator divided 1/2/4/8; 4 or 2 samples.
// - Detectors 1 and 2 expose readable level bits above or below threshold.
// - Detector 2 level bit reads 1 while detector 2 is disabled.
// - Enable and level registers survive software, watchdog and detector 1/2 resets.
// - Enable and control register writes take effect only while protect unlock is 1.
// - After an enable bit goes 0 to 1 the detector waits its settle time.
// - Interrupt/reset enable works only while that detector's circuit enable is 1.
// - Detector 0 unfiltered option is honoured only while its filter is disabled.
// - Rewriting detector 1/2 control may set its crossing flag; software clears it.
// - Crossing flags clear only on written 0; written 1 leaves them unchanged.
// - Interrupt-versus-reset mode bit works only while event enable is 1.
// - Single-edge direction bit applies only while both-edge select is 0.
// - Crossing and level bits survive software, watchdog and detector 1/2 resets.
// - Detector 1/2 sensing is shared with two comparators, used one way at a time.
// - After supply returns above threshold zero, count 32 slow cycles before release.
`ifndef SUPPLY_MONITOR_CONSTS_SVH
`define SUPPLY_MONITOR_CONSTS_SVH

// ----------------------------------------------------------------
// Detect enable register
// ----------------------------------------------------------------
`define EN_LOW_POWER_BIT 0
`define EN_DET0_BIT 5
`define EN_DET1_BIT 6
`define EN_DET2_BIT 7
`define EN_WRITE_MASK 8'hE1
`define EN_RESET_VALUE 8'h00

// ----------------------------------------------------------------
// Detector control registers
// ----------------------------------------------------------------
`define CTL_EVENT_EN_BIT 0
`define CTL_FILTER_DIS_BIT 1
`define CTL_FLAG_BIT 2
`define CTL_LEVEL_BIT 3
`define CTL_DIV_LSB 4
`define CTL_MODE_BIT 6
`define CTL_DIR_BIT 7
`define CTL_UNFILT_BIT 7
`define CTL0_WRITE_MASK 8'hB3
`define CTL12_WRITE_MASK 8'hF3
`define CTL_RESET_VALUE 8'h00

// ----------------------------------------------------------------
// Level and edge select registers
// ----------------------------------------------------------------
`define LVL_DET2_BIT 3
`define EDGE_DET1_BIT 1
`define EDGE_DET2_BIT 2
`define EDGE_WRITE_MASK 8'h06
`define EDGE_RESET_VALUE 8'h00

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CLOCK_MHZ 250
`define SETTLE_TIME_NS 100000
`define RESTART_TIME_NS 1000
`define DET0_RELEASE_COUNT 32
`define DET0_SAMPLES 4
`define DET12_SAMPLES 2

`endif

// ### src/supply_monitor_pkg.sv
// Types shared by the supply-voltage monitor control modules.
package supply_monitor_pkg;
  typedef logic [7:0] reg_byte_t;
  typedef logic [1:0] div_sel_t;
  // Gray coded along idle, hold, release.
  typedef enum logic [1:0]
  {
    DET0_IDLE = 2'h0,
    DET0_HOLD = 2'h1,
    DET0_RELEASE = 2'h3
  } det0_state_t;
endpackage : supply_monitor_pkg

// ### src/supply_voltage_monitor_control.sv
// Top of the supply-voltage monitor control: registers, crossing events, resets and interrupts.
`timescale 1ns/100ps
`include "supply_monitor_consts.svh"
module supply_voltage_monitor_control #(
  parameter int SETTLE_CYCLES = (`SETTLE_TIME_NS * `CLOCK_MHZ + 999) / 1000,
  parameter int RESTART_CYCLES = (`RESTART_TIME_NS * `CLOCK_MHZ + 999) / 1000
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic partialResetn,
  input wire logic slowOsc,
  input wire logic cmpAbove0,
  input wire logic cmpAbove1,
  input wire logic cmpAbove2,
  input wire logic comparatorMode,
  input wire logic protectUnlock,
  input wire logic enableWrite,
  input wire logic det0CtrlWrite,
  input wire logic det1CtrlWrite,
  input wire logic det2CtrlWrite,
  input wire logic edgeSelWrite,
  input wire supply_monitor_pkg::reg_byte_t writeData,
  output supply_monitor_pkg::reg_byte_t detectEnableReg,
  output supply_monitor_pkg::reg_byte_t det0CtrlReg,
  output supply_monitor_pkg::reg_byte_t det1CtrlReg,
  output supply_monitor_pkg::reg_byte_t det2CtrlReg,
  output supply_monitor_pkg::reg_byte_t detectLevelReg,
  output supply_monitor_pkg::reg_byte_t edgeSelReg,
  output logic det0ResetReq,
  output logic det1ResetReq,
  output logic det2ResetReq,
  output logic det1IrqReq,
  output logic det2IrqReq,
  output logic comparatorOut1,
  output logic comparatorOut2
);
  import supply_monitor_pkg::*;

  localparam int RW = $clog2(RESTART_CYCLES + 1);
  localparam logic [RW-1:0] RESTART_LAST = RW'(RESTART_CYCLES);
  localparam logic [5:0] RELEASE_LAST = 6'(`DET0_RELEASE_COUNT);

  if (RESTART_CYCLES < 1 || SETTLE_CYCLES < 1)
  begin : bad_param
    $error("supply_voltage_monitor_control timing parameters out of range");
  end

  reg_byte_t enable_q;
  reg_byte_t ctrl0_q;
  reg_byte_t ctrl_q [2];
  reg_byte_t edge_q;
  logic flag_q [2];
  logic prevLevel_q [2];
  logic irq_q [2];
  logic [RW-1:0] restart_q [2];
  logic ctrlWrite [2];
  logic event_ [2];
  logic cmpRaw [2];
  logic bothEdge [2];
  logic slowPrev_q;
  logic slowTick;
  logic cmpOut1_q;
  logic cmpOut2_q;
  det0_state_t det0State_q;
  logic [5:0] release_q;
  logic det0Active;

  det_channel_if ch0 ();
  det_channel_if ch1 ();
  det_channel_if ch2 ();

  // ----------------------------------------------------------------
  // Slow oscillator edge
  // ----------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    if (!resetn)
      slowPrev_q <= 1'b0;
    else
      slowPrev_q <= slowOsc;
  end
  assign slowTick = slowOsc && !slowPrev_q;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // Only the full reset clears these; the partial reset leaves them untouched.
  always_ff @(posedge clock)
  begin
    if (!resetn)
      enable_q <= `EN_RESET_VALUE;
    else if (enableWrite && protectUnlock)
      enable_q <= writeData & `EN_WRITE_MASK;
  end

  always_ff @(posedge clock)
  begin
    if (!resetn)
      ctrl0_q <= `CTL_RESET_VALUE;
    else if (det0CtrlWrite && protectUnlock)
      ctrl0_q <= writeData & `CTL0_WRITE_MASK;
  end

  // The edge select register is not among those kept over the partial reset.
  always_ff @(posedge clock)
  begin
    if (!resetn || !partialResetn)
      edge_q <= `EDGE_RESET_VALUE;
    else if (edgeSelWrite)
      edge_q <= writeData & `EDGE_WRITE_MASK;
  end

  assign ctrlWrite[0] = det1CtrlWrite && protectUnlock;
  assign ctrlWrite[1] = det2CtrlWrite && protectUnlock;
  assign cmpRaw[0] = cmpAbove1;
  assign cmpRaw[1] = cmpAbove2;
  assign bothEdge[0] = edge_q[`EDGE_DET1_BIT];
  assign bothEdge[1] = edge_q[`EDGE_DET2_BIT];

  // ----------------------------------------------------------------
  // Channels
  // ----------------------------------------------------------------
  // Comparator mode takes the shared sensing away from detectors 1 and 2.
  assign ch0.enable = enable_q[`EN_DET0_BIT];
  assign ch0.filterDisable = ctrl0_q[`CTL_FILTER_DIS_BIT];
  assign ch0.divSel = ctrl0_q[`CTL_DIV_LSB +: 2];
  assign ch1.enable = enable_q[`EN_DET1_BIT] && !comparatorMode;
  assign ch1.filterDisable = ctrl_q[0][`CTL_FILTER_DIS_BIT];
  assign ch1.divSel = ctrl_q[0][`CTL_DIV_LSB +: 2];
  assign ch2.enable = enable_q[`EN_DET2_BIT] && !comparatorMode;
  assign ch2.filterDisable = ctrl_q[1][`CTL_FILTER_DIS_BIT];
  assign ch2.divSel = ctrl_q[1][`CTL_DIV_LSB +: 2];

  detector_channel #(.SAMPLES(`DET0_SAMPLES), .SETTLE_CYCLES(SETTLE_CYCLES)) u_det0 (
    .clock(clock),
    .resetn(resetn),
    .slowTick(slowTick),
    .rawAbove(cmpAbove0),
    .ch(ch0.chan)
  );
  detector_channel #(.SAMPLES(`DET12_SAMPLES), .SETTLE_CYCLES(SETTLE_CYCLES)) u_det1 (
    .clock(clock),
    .resetn(resetn),
    .slowTick(slowTick),
    .rawAbove(cmpAbove1),
    .ch(ch1.chan)
  );
  detector_channel #(.SAMPLES(`DET12_SAMPLES), .SETTLE_CYCLES(SETTLE_CYCLES)) u_det2 (
    .clock(clock),
    .resetn(resetn),
    .slowTick(slowTick),
    .rawAbove(cmpAbove2),
    .ch(ch2.chan)
  );

  // ----------------------------------------------------------------
  // Detectors 1 and 2: crossings, flags, interrupts, resets
  // ----------------------------------------------------------------
  logic lvl [2];
  logic settledK [2];
  logic circuitOn [2];
  assign lvl[0] = ch1.level;
  assign lvl[1] = ch2.level;
  assign settledK[0] = ch1.settled;
  assign settledK[1] = ch2.settled;
  assign circuitOn[0] = ch1.enable;
  assign circuitOn[1] = ch2.enable;

  for (genvar k = 0; k < 2; k++)
  begin : g_det
    logic rise;
    logic fall;
    logic armed;
    assign rise = lvl[k] && !prevLevel_q[k];
    assign fall = !lvl[k] && prevLevel_q[k];
    assign armed = circuitOn[k] && settledK[k] && ctrl_q[k][`CTL_EVENT_EN_BIT];
    // The direction bit only matters for single-edge operation.
    assign event_[k] = bothEdge[k] ? (rise || fall) :
      (ctrl_q[k][`CTL_DIR_BIT] ? fall : rise);

    always_ff @(posedge clock)
    begin
      if (!resetn)
        prevLevel_q[k] <= 1'b1;
      else
        prevLevel_q[k] <= lvl[k];
    end

    always_ff @(posedge clock)
    begin
      if (!resetn)
        ctrl_q[k] <= `CTL_RESET_VALUE;
      else if (ctrlWrite[k])
        ctrl_q[k] <= writeData & `CTL12_WRITE_MASK;
    end

    // A crossing in the same cycle as a clearing write keeps the flag set.
    always_ff @(posedge clock)
    begin
      if (!resetn)
        flag_q[k] <= 1'b0;
      else if (circuitOn[k] && settledK[k] && event_[k])
        flag_q[k] <= 1'b1;
      else if (ctrlWrite[k] && !writeData[`CTL_FLAG_BIT])
        flag_q[k] <= 1'b0;
    end

    always_ff @(posedge clock)
    begin
      if (!resetn)
        irq_q[k] <= 1'b0;
      else
        irq_q[k] <= armed && event_[k] && !ctrl_q[k][`CTL_MODE_BIT];
    end

    // The reset stands a fixed time from the crossing, not until supply recovers.
    always_ff @(posedge clock)
    begin
      if (!resetn)
        restart_q[k] <= '0;
      else if (armed && event_[k] && ctrl_q[k][`CTL_MODE_BIT])
        restart_q[k] <= RESTART_LAST;
      else if (restart_q[k] != '0)
        restart_q[k] <= restart_q[k] - RW'(1);
    end
  end

  // ----------------------------------------------------------------
  // Detector 0 reset
  // ----------------------------------------------------------------
  // The unfiltered option only arms detection while the filter is bypassed.
  assign det0Active = ch0.enable && ch0.settled && ctrl0_q[`CTL_EVENT_EN_BIT] &&
    (!ctrl0_q[`CTL_FILTER_DIS_BIT] || ctrl0_q[`CTL_UNFILT_BIT]);

  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      det0State_q <= DET0_IDLE;
      release_q <= 6'h00;
    end
    else
    begin
      case (det0State_q)
        DET0_IDLE:
        begin
          if (det0Active && !ch0.level)
            det0State_q <= DET0_HOLD;
        end
        DET0_HOLD:
        begin
          release_q <= 6'h00;
          if (ch0.level)
            det0State_q <= DET0_RELEASE;
        end
        DET0_RELEASE:
        begin
          if (!ch0.level)
            det0State_q <= DET0_HOLD;
          else if (slowTick)
          begin
            release_q <= release_q + 6'h01;
            if (release_q == RELEASE_LAST - 6'h01)
              det0State_q <= DET0_IDLE;
          end
        end
        default: det0State_q <= DET0_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Comparator outputs and read-back
  // ----------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      cmpOut1_q <= 1'b0;
      cmpOut2_q <= 1'b0;
    end
    else
    begin
      cmpOut1_q <= comparatorMode && cmpRaw[0];
      cmpOut2_q <= comparatorMode && cmpRaw[1];
    end
  end

  always_comb
  begin
    detectEnableReg = enable_q;
    det0CtrlReg = ctrl0_q;
    det1CtrlReg = ctrl_q[0];
    det1CtrlReg[`CTL_FLAG_BIT] = flag_q[0];
    det1CtrlReg[`CTL_LEVEL_BIT] = ch1.level;
    det2CtrlReg = ctrl_q[1];
    det2CtrlReg[`CTL_FLAG_BIT] = flag_q[1];
    detectLevelReg = 8'h00;
    // Channel 2 forces its level high while disabled.
    detectLevelReg[`LVL_DET2_BIT] = ch2.level;
    edgeSelReg = edge_q;
  end

  assign det0ResetReq = (det0State_q != DET0_IDLE);
  assign det1ResetReq = (restart_q[0] != '0);
  assign det2ResetReq = (restart_q[1] != '0);
  assign det1IrqReq = irq_q[0];
  assign det2IrqReq = irq_q[1];
  assign comparatorOut1 = cmpOut1_q;
  assign comparatorOut2 = cmpOut2_q;
endmodule : supply_voltage_monitor_control
